// ---- hw/csr_pkg.sv ----
// Constants, types and state layout of the CPU special register block
package csr_pkg;
    // Data-memory locations of the special registers
    localparam logic [7:0] A_IND0    = 8'h00;
    localparam logic [7:0] A_PTR0    = 8'h01;
    localparam logic [7:0] A_IND1    = 8'h02;
    localparam logic [7:0] A_PTR1    = 8'h03;
    localparam logic [7:0] A_BANK    = 8'h04;
    localparam logic [7:0] A_WORK    = 8'h05;
    localparam logic [7:0] A_PC_LOW  = 8'h06;
    localparam logic [7:0] A_TAB_PTR = 8'h07;
    localparam logic [7:0] A_TAB_HI  = 8'h08;
    localparam logic [7:0] A_FLAGS   = 8'h0A;
    localparam logic [7:0] A_RAM_LO  = 8'h40;
    localparam logic [7:0] A_RAM_HI  = 8'h7F;
    localparam int         RAM_WORDS = 128;

    // Bus word indices: below 0x100 is the data space, one location per word
    localparam logic [9:0] IDX_CMD   = 10'h100;

    // Command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_ARG_LSB = 8;
    localparam int CMD_TGT_LSB = 16;

    // Flag bit positions
    localparam int B_C     = 0;
    localparam int B_HALF  = 1;
    localparam int B_Z     = 2;
    localparam int B_WRAP  = 3;
    localparam int B_SLEEP = 4;
    localparam int B_WDOG  = 5;

    // Command opcodes
    localparam logic [3:0] OP_LOAD   = 4'h0;
    localparam logic [3:0] OP_STORE  = 4'h1;
    localparam logic [3:0] OP_ADD    = 4'h2;
    localparam logic [3:0] OP_SUB    = 4'h3;
    localparam logic [3:0] OP_AND    = 4'h4;
    localparam logic [3:0] OP_OR     = 4'h5;
    localparam logic [3:0] OP_XOR    = 4'h6;
    localparam logic [3:0] OP_RLC    = 4'h7;
    localparam logic [3:0] OP_RRC    = 4'h8;
    localparam logic [3:0] OP_TABRD  = 4'h9;
    localparam logic [3:0] OP_KICK   = 4'hA;
    localparam logic [3:0] OP_HALT   = 4'hB;
    localparam logic [3:0] OP_CALL   = 4'hC;
    localparam logic [3:0] OP_RET    = 4'hD;

    localparam int         STACK_DEPTH = 4;
    localparam logic [2:0] SP_FULL     = 3'h4;
    localparam logic [9:0] PC_STEP     = 10'h001;

    typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_DUMMY} csr_fsm_t;

    typedef struct packed {
        csr_fsm_t                        st;
        logic [7:0]                      work;
        logic [7:0]                      ptr0;
        logic [7:0]                      ptr1;
        logic                            bank;
        logic [9:0]                      pc;
        logic [7:0]                      tab_ptr;
        logic [5:0]                      tab_hi;
        logic                            c;
        logic                            half;
        logic                            z;
        logic                            wrap;
        logic                            sleep;
        logic                            to;
        logic [STACK_DEPTH-1:0][9:0]     stack;
        logic [2:0]                      sp;
        logic [7:0]                      op_arg;
        logic                            ack;
        logic [31:0]                     dat;
        logic [9:0]                      pm_addr;
        logic                            pm_rd;
        logic                            dummy;
    } csr_state_t;

    localparam csr_state_t CSR_RESET = '0;
endpackage : csr_pkg

// ---- hw/csr_core.sv ----
// CPU special function registers with a classic Wishbone slave
`timescale 1ns/1ps

// Overview of operation
// - Indirect port 0 reaches bank 0 via its pointer; port 1 any bank.
// - Indirect access aimed at an indirect port reads zero, writes nothing.
// - Both pointers are ordinary readable and writable data locations.
// - ALU results land in the working register; moves pass through it.
// - Writing the low program counter byte jumps in-page; bus and store writes add a dummy cycle.
// - Table read fetches word at table pointer; high part latched, low stored.
// - Flag register writes change arithmetic flags only, not system flags.
// - Watchdog flag cleared by power-up, clear or stop; set by time-out.
// - Sleep flag cleared by power-up or watchdog clear; set by stop.
// - Carry set on add carry or subtract without borrow; rotates use it.
// - Half carry set on low-nibble carry or no nibble borrow.
// - Zero flag follows a zero arithmetic or logic result.
// - Overflow flag is carry into MSB xor carry out of MSB.
// - Calls push only the return address, never the flags.
// - Indirect effective address is the matching pointer's current value.
module csr_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Program memory table port
    output logic      [9:0]  pm_addr,
    output logic             pm_rd,
    input  wire logic [13:0] pm_data,
    // Core status
    input  wire logic        wdt_timeout,
    output logic      [9:0]  pc,
    output logic             dummy_cycle,
    output logic      [7:0]  working_register,
    output logic      [7:0]  cpu_flags
);
    csr_pkg::csr_state_t s;
    csr_pkg::csr_state_t n;
    logic [7:0]          ram [0:csr_pkg::RAM_WORDS-1];
    logic                ram_we;
    logic [6:0]          ram_idx;
    logic [7:0]          ram_wd;
    logic [6:0]          ram_ridx;
    logic [7:0]          ram_q;

    // Effective address {null, bank, location}
    function automatic logic [9:0] resolve(input csr_pkg::csr_state_t st, input logic [7:0] a);
        logic nul;
        nul = 1'b0;
        if (a == csr_pkg::A_IND0) begin
            nul = (st.ptr0 == csr_pkg::A_IND0) || (st.ptr0 == csr_pkg::A_IND1);
            return {nul, 1'b0, st.ptr0};
        end else if (a == csr_pkg::A_IND1) begin
            nul = (st.ptr1 == csr_pkg::A_IND0) || (st.ptr1 == csr_pkg::A_IND1);
            return {nul, st.bank, st.ptr1};
        end
        return {nul, 1'b0, a};
    endfunction : resolve

    function automatic logic is_ram(input logic [9:0] ea);
        return !ea[9] && ea[7:0] >= csr_pkg::A_RAM_LO && ea[7:0] <= csr_pkg::A_RAM_HI;
    endfunction : is_ram

    function automatic logic [7:0] read_loc(input csr_pkg::csr_state_t st, input logic [9:0] ea,
                                            input logic [7:0] rq);
        if (ea[9]) begin
            return 8'h00;
        end
        if (is_ram(ea)) begin
            return rq;
        end
        unique case (ea[7:0])
            csr_pkg::A_PTR0:    return st.ptr0;
            csr_pkg::A_PTR1:    return st.ptr1;
            csr_pkg::A_BANK:    return {7'h00, st.bank};
            csr_pkg::A_WORK:    return st.work;
            csr_pkg::A_PC_LOW:  return st.pc[7:0];
            csr_pkg::A_TAB_PTR: return st.tab_ptr;
            csr_pkg::A_TAB_HI:  return {2'b00, st.tab_hi};
            csr_pkg::A_FLAGS:   return {2'b00, st.to, st.sleep, st.wrap, st.z, st.half, st.c};
            default:            return 8'h00;
        endcase
    endfunction : read_loc

    // Special register stores; RAM is written by the caller
    function automatic csr_pkg::csr_state_t store(input csr_pkg::csr_state_t st, input logic [9:0] ea,
                                                  input logic [7:0] d);
        csr_pkg::csr_state_t r;
        r = st;
        if (!ea[9]) begin
            unique case (ea[7:0])
                csr_pkg::A_PTR0:    r.ptr0 = d;
                csr_pkg::A_PTR1:    r.ptr1 = d;
                csr_pkg::A_BANK:    r.bank = d[0];
                csr_pkg::A_WORK:    r.work = d;
                csr_pkg::A_PC_LOW:  r.pc = {st.pc[9:8], d};
                csr_pkg::A_TAB_PTR: r.tab_ptr = d;
                csr_pkg::A_TAB_HI:  r.tab_hi = d[5:0];
                csr_pkg::A_FLAGS: begin
                    r.wrap = d[csr_pkg::B_WRAP];
                    r.z    = d[csr_pkg::B_Z];
                    r.half = d[csr_pkg::B_HALF];
                    r.c    = d[csr_pkg::B_C];
                end
                default: r = st;
            endcase
        end
        return r;
    endfunction : store

    function automatic logic is_pc_low(input logic [9:0] ea);
        return !ea[9] && ea[7:0] == csr_pkg::A_PC_LOW;
    endfunction : is_pc_low

    // Returns {ov, ac, c, sum}
    function automatic logic [10:0] alu_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [7:0] mid;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        mid  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {mid[7] ^ full[8], lo[4], full[8], full[7:0]};
    endfunction : alu_add

    logic [9:0]  idx;
    logic [3:0]  op;
    logic [9:0]  bus_ea;
    logic [9:0]  cmd_ea;
    logic [9:0]  sel_ea;
    logic [9:0]  tbl_ea;
    logic [7:0]  m;
    logic [10:0] sum;
    logic        req;
    logic        jump;

    assign idx      = wb_adr_i[11:2];
    assign op       = wb_dat_i[csr_pkg::CMD_OP_LSB +: 4];
    assign bus_ea   = resolve(s, idx[7:0]);
    assign cmd_ea   = resolve(s, wb_dat_i[csr_pkg::CMD_ARG_LSB +: 8]);
    assign tbl_ea   = resolve(s, s.op_arg);
    assign sel_ea   = (idx == csr_pkg::IDX_CMD) ? cmd_ea : bus_ea;
    assign ram_ridx = {sel_ea[8], sel_ea[5:0]};
    assign ram_q    = ram[ram_ridx];
    assign m        = read_loc(s, sel_ea, ram_q);

    always_comb begin
        n       = s;
        n.ack   = 1'b0;
        n.pm_rd = 1'b0;
        n.dummy = 1'b0;
        ram_we  = 1'b0;
        ram_idx = 7'h00;
        ram_wd  = 8'h00;
        jump    = 1'b0;
        sum     = 11'h000;
        req     = wb_cyc_i && wb_stb_i && !s.ack;
        unique case (s.st)
            csr_pkg::ST_IDLE: begin
                if (req && idx[9:8] == 2'b00) begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        n       = store(n, bus_ea, wb_dat_i[7:0]);
                        ram_we  = is_ram(bus_ea);
                        ram_idx = {bus_ea[8], bus_ea[5:0]};
                        ram_wd  = wb_dat_i[7:0];
                        jump    = is_pc_low(bus_ea);
                    end else if (!wb_we_i) begin
                        n.dat = {24'h00_0000, m};
                    end
                end else if (req && idx == csr_pkg::IDX_CMD) begin
                    if (!wb_we_i) begin
                        n.dat = {19'h0_0000, s.sp, s.pc};
                    end else if (wb_sel_i[0]) begin
                        unique case (op)
                            csr_pkg::OP_LOAD: n.work = m;
                            csr_pkg::OP_STORE: begin
                                n       = store(n, cmd_ea, s.work);
                                ram_we  = is_ram(cmd_ea);
                                ram_idx = {cmd_ea[8], cmd_ea[5:0]};
                                ram_wd  = s.work;
                                jump    = is_pc_low(cmd_ea);
                            end
                            csr_pkg::OP_ADD, csr_pkg::OP_SUB: begin
                                sum    = (op == csr_pkg::OP_ADD) ? alu_add(s.work, m, 1'b0)
                                                                 : alu_add(s.work, ~m, 1'b1);
                                n.work = sum[7:0];
                                n.c    = sum[8];
                                n.half = sum[9];
                                n.wrap = sum[10];
                                n.z    = sum[7:0] == 8'h00;
                            end
                            csr_pkg::OP_AND, csr_pkg::OP_OR, csr_pkg::OP_XOR: begin
                                n.work = (op == csr_pkg::OP_AND) ? (s.work & m) :
                                         (op == csr_pkg::OP_OR)  ? (s.work | m) : (s.work ^ m);
                                n.z    = n.work == 8'h00;
                            end
                            csr_pkg::OP_RLC: {n.c, n.work} = {s.work, s.c};
                            csr_pkg::OP_RRC: {n.work, n.c} = {s.c, s.work};
                            csr_pkg::OP_TABRD: begin
                                n.pm_addr = {s.pc[9:8], s.tab_ptr};
                                n.pm_rd   = 1'b1;
                                n.op_arg  = wb_dat_i[csr_pkg::CMD_ARG_LSB +: 8];
                            end
                            csr_pkg::OP_KICK: begin
                                n.to    = 1'b0;
                                n.sleep = 1'b0;
                            end
                            csr_pkg::OP_HALT: begin
                                n.to    = 1'b0;
                                n.sleep = 1'b1;
                            end
                            csr_pkg::OP_CALL: begin
                                if (s.sp != csr_pkg::SP_FULL) begin
                                    n.stack[s.sp[1:0]] = s.pc + csr_pkg::PC_STEP;
                                    n.sp               = s.sp + 3'h1;
                                end
                            end
                            csr_pkg::OP_RET: begin
                                if (s.sp != 3'h0) begin
                                    n.sp = s.sp - 3'h1;
                                end
                            end
                            default: n = n;
                        endcase
                        // Program counter step or redirect
                        if (op == csr_pkg::OP_CALL) begin
                            n.pc = wb_dat_i[csr_pkg::CMD_TGT_LSB +: 10];
                        end else if (op == csr_pkg::OP_RET && s.sp != 3'h0) begin
                            n.pc = s.stack[n.sp[1:0]];
                        end else if (!jump) begin
                            n.pc = s.pc + csr_pkg::PC_STEP;
                        end
                    end
                end else if (req) begin
                    n.dat = 32'h0000_0000;
                end
                // Finish: table read waits a cycle, a program counter low write adds a dummy cycle
                if (req) begin
                    if (n.pm_rd) begin
                        n.st = csr_pkg::ST_TABLE;
                    end else if (jump) begin
                        n.st    = csr_pkg::ST_DUMMY;
                        n.dummy = 1'b1;
                    end else begin
                        n.ack = 1'b1;
                    end
                end
            end
            csr_pkg::ST_TABLE: begin
                n.tab_hi = pm_data[13:8];
                n       = store(n, tbl_ea, pm_data[7:0]);
                ram_we  = is_ram(tbl_ea);
                ram_idx = {tbl_ea[8], tbl_ea[5:0]};
                ram_wd  = pm_data[7:0];
                n.ack   = 1'b1;
                n.st    = csr_pkg::ST_IDLE;
            end
            csr_pkg::ST_DUMMY: begin
                n.ack = 1'b1;
                n.st  = csr_pkg::ST_IDLE;
            end
            default: n.st = csr_pkg::ST_IDLE;
        endcase
        // Time-out wins over a clear in the same cycle
        if (wdt_timeout) begin
            n.to = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= csr_pkg::CSR_RESET;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (ram_we) begin
            ram[ram_idx] <= ram_wd;
        end
    end

    assign wb_dat_o         = s.dat;
    assign wb_ack_o         = s.ack;
    assign pm_addr          = s.pm_addr;
    assign pm_rd            = s.pm_rd;
    assign pc               = s.pc;
    assign dummy_cycle      = s.dummy;
    assign working_register = s.work;
    assign cpu_flags        = {2'b00, s.to, s.sleep, s.wrap, s.z, s.half, s.c};
endmodule : csr_core

// ---- tb/csr_checker.sv ----
// Port assertions for the special register block
`timescale 1ns/1ps
module csr_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Table port
    input wire logic [9:0]  pm_addr,
    input wire logic        pm_rd,
    input wire logic [13:0] pm_data,
    // Core status
    input wire logic        wdt_timeout,
    input wire logic [9:0]  pc,
    input wire logic        dummy_cycle,
    input wire logic [7:0]  working_register,
    input wire logic [7:0]  cpu_flags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    flag_top_a: assert property (cpu_flags[7:6] == 2'b00) else $error("flag top bits set");
    dummy_ack_a: assert property (dummy_cycle |=> wb_ack_o) else $error("no ack after dummy");
    dummy_page_a: assert property (dummy_cycle |-> pc[9:8] == $past(pc[9:8])) else $error("page moved");
    table_ack_a: assert property (pm_rd |=> wb_ack_o && !pm_rd) else $error("table read timing");
    wdt_set_a: assert property (wdt_timeout |=> cpu_flags[5]) else $error("watchdog flag not set");
    wdt_only_a: assert property ($rose(cpu_flags[5]) |-> $past(wdt_timeout)) else $error("watchdog rose");
    wdt_clear_a: assert property ($fell(cpu_flags[5]) |-> wb_ack_o) else $error("watchdog fell");
    sleep_set_a: assert property ($rose(cpu_flags[4]) |-> wb_ack_o && $past(wb_we_i)) else $error("sleep rose");
    acc_move_a: assert property ($changed(working_register) |-> wb_ack_o) else $error("acc moved");

    cover property (dummy_cycle);
    cover property (pm_rd);
    cover property ($rose(cpu_flags[4]));
endmodule : csr_checker

bind csr_core csr_checker csr_checker_inst (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .wdt_timeout(wdt_timeout),
    .pc(pc), .dummy_cycle(dummy_cycle), .working_register(working_register), .cpu_flags(cpu_flags));

// ---- tb/cpu_special_registers_tb_top.sv ----
// Self-checking bench for the special register block
`timescale 1ns/1ps
module cpu_special_registers_tb_top;
    logic        clk, srst, cyc, stb, we, wdt, ack, rd_s, dmy, dmy_seen;
    logic [11:0] adr;
    logic [31:0] wdat, rdat, dat_o;
    logic [13:0] pm_data, w;
    logic [9:0]  pm_addr, pm_seen, pc, exp_pc, ta;
    logic [7:0]  work, flags;
    logic [3:0]  sel, sel_v;
    logic [9:0]  stk[$];
    logic [47:0] rows [10];
    int          mismatches, checked, cycles;

    csr_core csr_core_inst (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pm_addr(pm_addr), .pm_rd(rd_s), .pm_data(pm_data), .wdt_timeout(wdt), .pc(pc),
        .dummy_cycle(dmy), .working_register(work), .cpu_flags(flags));

    // Program word valid only while the table read is pending
    assign pm_data = rd_s ? {pm_addr[3:0], pm_addr} ^ 14'h01a5 : ~{pm_addr[3:0], pm_addr};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    always @(negedge clk) begin
        if (dmy === 1'b1) dmy_seen = 1'b1;
        if (rd_s === 1'b1) pm_seen = pm_addr;
    end

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic w_en, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w_en;
        sel  <= sel_v;
        adr  <= {idx, 2'b00};
        wdat <= d;
        // Request stands until ack is sampled high at a rising edge
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] loc, input logic [7:0] d);
        xfer(1'b1, 10'(loc), 32'(d));
    endtask : wr

    task automatic rd(input logic [7:0] loc, input logic [7:0] exp);
        xfer(1'b0, 10'(loc), 32'h0000_0000);
        chk(rdat, 32'(exp));
    endtask : rd

    task automatic cmd(input logic [3:0] op, input logic [7:0] arg, input logic [9:0] tgt);
        xfer(1'b1, csr_pkg::IDX_CMD, {6'h00, tgt, arg, 4'h0, op});
        if (op == csr_pkg::OP_CALL) begin
            if (stk.size() < 4) stk.push_back(exp_pc + 10'h001);
            exp_pc = tgt;
        end else if (op == csr_pkg::OP_RET && stk.size() > 0) begin
            exp_pc = stk.pop_back();
        end else begin
            exp_pc = exp_pc + 10'h001;
        end
    endtask : cmd

    task automatic wdt_pulse;
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        @(negedge clk);
    endtask : wdt_pulse

    initial begin
        {cyc, stb, we, wdt, dmy_seen} = '0;
        sel = 4'h0;
        sel_v = 4'h1;
        {adr, wdat, exp_pc, pm_seen, mismatches, checked, cycles} = '0;
        srst = 1'b1;
        // Op, preset flags, working value, operand, result, low flags {wrap,z,half,c}
        rows = '{48'h02_00_7f_01_80_0a, 48'h02_00_ff_01_00_07, 48'h03_00_10_01_0f_01,
                 48'h03_00_80_01_7f_09, 48'h03_00_05_05_00_07, 48'h04_09_f0_0f_00_0d,
                 48'h05_04_12_21_33_00, 48'h06_00_5a_5a_00_04, 48'h07_00_81_00_02_01,
                 48'h08_01_02_00_81_00};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(32'(flags & 8'hf0), 32'h0000_0000);
        $display("test reset done");
        wr(csr_pkg::A_PTR0, 8'h40);
        wr(csr_pkg::A_IND0, 8'h5a);
        rd(csr_pkg::A_RAM_LO, 8'h5a);
        rd(csr_pkg::A_PTR0, 8'h40);
        wr(8'h41, 8'h11);
        wr(csr_pkg::A_BANK, 8'h01);
        wr(csr_pkg::A_PTR1, 8'h41);
        wr(csr_pkg::A_IND1, 8'h33);
        rd(csr_pkg::A_IND1, 8'h33);
        rd(8'h41, 8'h11);
        wr(csr_pkg::A_BANK, 8'h00);
        rd(csr_pkg::A_IND1, 8'h11);
        wr(csr_pkg::A_PTR0, csr_pkg::A_IND1);
        wr(csr_pkg::A_IND0, 8'h77);
        rd(csr_pkg::A_IND0, 8'h00);
        rd(csr_pkg::A_PTR1, 8'h41);
        rd(csr_pkg::A_IND1, 8'h11);
        wr(8'h0b, 8'h55);
        rd(8'h0b, 8'h00);
        // Write without byte lane 0 leaves the location untouched
        sel_v = 4'h0;
        wr(8'h41, 8'hee);
        sel_v = 4'h1;
        rd(8'h41, 8'h11);
        xfer(1'b0, 10'h200, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        $display("test indirect done");
        cmd(csr_pkg::OP_LOAD, csr_pkg::A_RAM_LO, 10'h000);
        chk(32'(work), 32'h0000_005a);
        cmd(csr_pkg::OP_STORE, 8'h42, 10'h000);
        rd(8'h42, 8'h5a);
        foreach (rows[i]) begin
            wr(csr_pkg::A_FLAGS, rows[i][39:32]);
            wr(csr_pkg::A_WORK, rows[i][31:24]);
            wr(csr_pkg::A_RAM_LO, rows[i][23:16]);
            cmd(rows[i][43:40], csr_pkg::A_RAM_LO, 10'h000);
            chk(32'(work), 32'(rows[i][15:8]));
            chk(32'(flags & 8'h0f), 32'(rows[i][7:0]));
        end
        wr(csr_pkg::A_FLAGS, 8'hff);
        rd(csr_pkg::A_FLAGS, 8'h0f);
        $display("test alu done");
        wdt_pulse();
        wr(csr_pkg::A_FLAGS, 8'h00);
        rd(csr_pkg::A_FLAGS, 8'h20);
        cmd(csr_pkg::OP_HALT, 8'h00, 10'h000);
        chk(32'(flags & 8'h30), 32'h0000_0010);
        wdt_pulse();
        wr(csr_pkg::A_FLAGS, 8'h00);
        rd(csr_pkg::A_FLAGS, 8'h30);
        cmd(csr_pkg::OP_KICK, 8'h00, 10'h000);
        chk(32'(flags & 8'h30), 32'h0000_0000);
        $display("test system flags done");
        wr(csr_pkg::A_FLAGS, 8'h05);
        cmd(csr_pkg::OP_CALL, 8'h00, 10'h2f0);
        chk(32'(pc), 32'(exp_pc));
        wr(csr_pkg::A_FLAGS, 8'h0a);
        dmy_seen = 1'b0;
        wr(csr_pkg::A_PC_LOW, 8'h12);
        exp_pc = {exp_pc[9:8], 8'h12};
        chk(32'(pc), 32'(exp_pc));
        chk(32'(dmy_seen), 32'h0000_0001);
        wr(csr_pkg::A_TAB_PTR, 8'h34);
        ta = {exp_pc[9:8], 8'h34};
        w = {ta[3:0], ta} ^ 14'h01a5;
        cmd(csr_pkg::OP_TABRD, 8'h43, 10'h000);
        chk(32'(pm_seen), 32'(ta));
        rd(csr_pkg::A_TAB_HI, {2'b00, w[13:8]});
        rd(8'h43, w[7:0]);
        cmd(csr_pkg::OP_RET, 8'h00, 10'h000);
        xfer(1'b0, csr_pkg::IDX_CMD, 32'h0000_0000);
        chk(32'(rdat[9:0]), 32'(exp_pc));
        chk(32'(flags & 8'h0f), 32'h0000_000a);
        $display("test program flow done");
        give_verdict();
    end
endmodule : cpu_special_registers_tb_top
